/* rtl/burst2_consts.vh */
// constants of the burst-of-two common-io sram port
`ifndef BURST2_CONSTS_VH
`define BURST2_CONSTS_VH

// data word, byte lanes, address width and array depth
`define DATA_W          36
`define LANE_W          9
`define LANES           4
`define ADDR_W          4
`define MEM_DEPTH       16

// clock: one clock period is half a k cycle
`define CLK_PERIOD_NS   5
`define HALF_PER_K      2

// read: first word at t+1.5, second at t+2.0 (in k cycles)
`define RD_LAT_HALF     3
// write: first word at t+3.0, second at t+3.5 (edges WR_LAT_HALF-2 and WR_LAT_HALF-1, in half k cycles)
`define WR_LAT_HALF     8
`define WR_PIPE         7

// write buffer
`define WBUF_DEPTH      32
`define WBUF_PTR_W      5
`define WBUF_W          44

// reset value and lane enable masks
`define DQ_RST          36'h000000000
`define LANE_EN_NONE    4'h0
`define LANE_EN_NARROW  4'h3

`endif

/* rtl/burst2_fifo.v */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module burst2_fifo #(
    parameter WIDTH = 44,
    parameter DEPTH = 32,
    parameter PTR_W = 5
) (
    // clock and reset
    input  wire             clock,
    input  wire             rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg  [WIDTH-1:0] store_r [0:DEPTH-1];
    reg  [PTR_W-1:0] wr_ptr_r;
    reg  [PTR_W-1:0] rd_ptr_r;
    reg  [PTR_W:0]   count_r;
    wire             push;
    wire             pop;

    assign in_ready  = (count_r != DEPTH[PTR_W:0]);
    assign out_valid = (count_r != {(PTR_W+1){1'b0}});
    assign out_data  = store_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clock) begin
        if (push) begin
            store_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= {PTR_W{1'b0}};
            rd_ptr_r <= {PTR_W{1'b0}};
            count_r  <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}}
                                                                  : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}}
                                                                  : rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule // burst2_fifo

/* rtl/burst2_cio_sram_port.v */
// burst-of-two common-io synchronous sram port, one clock per half k cycle
//
// What this block does
// - load low, select high at k rise: read command, two-beat read burst starts.
// - load low, select low at k rise: write command, two-beat write burst starts.
// - narrow mode: masks 0 and 1 gate two lanes per beat; both high aborts.
// - wide mode: four masks gate four lanes per beat; all high aborts beat.
// - first beat masks and data at k rise, second beat at k# rise.
// - a no-operation does not cut a read short; idle data pins float.
`timescale 1ns/10ps
`include "burst2_consts.vh"
module burst2_cio_sram_port (
    // clock and reset
    input  wire                 clock,
    input  wire                 rst,
    // command pins
    input  wire                 load_strobe_n,
    input  wire                 rw_select,
    input  wire [`ADDR_W-1:0]   address,
    input  wire                 narrow_mode,
    // byte masks, active low
    input  wire                 byte_mask_lane0_n,
    input  wire                 byte_mask_lane1_n,
    input  wire                 byte_mask_lane2_n,
    input  wire                 byte_mask_lane3_n,
    // common data pins
    input  wire [`DATA_W-1:0]   dq_in,
    output wire [`DATA_W-1:0]   dq_out,
    output wire [`DATA_W-1:0]   dq_oe,
    // phase and buffer state
    output wire                 k_rise,
    output wire                 write_buffer_ready
);

    // ------------------------------------------------------------
    // half-cycle phase
    // ------------------------------------------------------------
    // phase 0 is the k rising edge, phase 1 the k# rising edge
    // a k rise comes first, so the first edge after reset may take a command
    reg                 phase_r;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    assign k_rise = ~phase_r;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire                cmd_read;
    wire                cmd_write;

    // the k# half of each k cycle carries second write beats and first read words, never commands
    // commands are registered only on k rises; no-operation starts nothing
    assign cmd_read  = ~phase_r & ~load_strobe_n & rw_select;
    assign cmd_write = ~phase_r & ~load_strobe_n & ~rw_select;

    // ------------------------------------------------------------
    // read pipeline
    // ------------------------------------------------------------
    reg  [`RD_LAT_HALF:0]   rd_v_r;
    reg  [`ADDR_W-1:0]      rd_a_r [0:`RD_LAT_HALF];
    reg  [`DATA_W-1:0]      dq_out_r;
    reg                     dq_oe_r;
    reg  [`DATA_W-1:0]      mem_r [0:`MEM_DEPTH-1];
    wire                    rd_beat0;
    wire                    rd_beat1;
    wire                    read_busy;
    integer                 i;

    // stage k is set by the k-th edge after the command edge; a word loaded
    // on an edge is seen after it, so word0 leaves on edge t+1.5 and
    // word1 on edge t+2.0
    assign rd_beat0  = rd_v_r[`RD_LAT_HALF-1];
    assign rd_beat1  = rd_v_r[`RD_LAT_HALF];
    assign read_busy = |rd_v_r;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_v_r <= {(`RD_LAT_HALF+1){1'b0}};
            for (i = 0; i <= `RD_LAT_HALF; i = i + 1) begin
                rd_a_r[i] <= {`ADDR_W{1'b0}};
            end
        end else begin
            rd_v_r <= {rd_v_r[`RD_LAT_HALF-1:0], cmd_read};
            rd_a_r[0] <= address;
            for (i = 1; i <= `RD_LAT_HALF; i = i + 1) begin
                rd_a_r[i] <= rd_a_r[i-1];
            end
        end
    end

    // a no-operation never clears the pipeline, so bursts in flight finish
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            dq_out_r <= `DQ_RST;
            dq_oe_r  <= 1'b0;
        end else if (rd_beat0) begin
            dq_out_r <= mem_r[rd_a_r[`RD_LAT_HALF-1]];
            dq_oe_r  <= 1'b1;
        end else if (rd_beat1) begin
            // linear burst: second address flips the low bit
            dq_out_r <= mem_r[rd_a_r[`RD_LAT_HALF] ^ {{(`ADDR_W-1){1'b0}}, 1'b1}];
            dq_oe_r  <= 1'b1;
        end else begin
            dq_oe_r  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // data pin drive
    // ------------------------------------------------------------
    // the pins float whenever no read word is due, so the controller
    // may put write data on them from the next clock on
    assign dq_out = dq_out_r;
    assign dq_oe  = {`DATA_W{dq_oe_r}};

    // ------------------------------------------------------------
    // write pipeline and beat capture
    // ------------------------------------------------------------
    reg  [`WR_PIPE-1:0]     wr_v_r;
    reg  [`ADDR_W-1:0]      wr_a_r [0:`WR_PIPE-1];
    reg  [`LANES-1:0]       lane_en;
    wire                    wr_beat0;
    wire                    wr_beat1;
    wire [`ADDR_W-1:0]      beat_addr;
    wire                    beat_push;
    wire                    fifo_in_ready;
    integer                 w;

    // capture stages: t+3.0 lands on a k rise, t+3.5 on the k# rise after it
    // the pins must be free of read data at both capture edges
    assign wr_beat0  = wr_v_r[`WR_LAT_HALF-3];
    assign wr_beat1  = wr_v_r[`WR_LAT_HALF-2];
    assign beat_addr = wr_beat0 ? wr_a_r[`WR_LAT_HALF-3]
                                : (wr_a_r[`WR_LAT_HALF-2] ^ {{(`ADDR_W-1){1'b0}}, 1'b1});

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_v_r <= {`WR_PIPE{1'b0}};
            for (w = 0; w < `WR_PIPE; w = w + 1) begin
                wr_a_r[w] <= {`ADDR_W{1'b0}};
            end
        end else begin
            wr_v_r <= {wr_v_r[`WR_PIPE-2:0], cmd_write};
            wr_a_r[0] <= address;
            for (w = 1; w < `WR_PIPE; w = w + 1) begin
                wr_a_r[w] <= wr_a_r[w-1];
            end
        end
    end

    // lane enables from the active-low masks sampled with the beat
    // narrow mode ignores the upper two masks whatever their level
    always @* begin
        lane_en = ~{byte_mask_lane3_n, byte_mask_lane2_n,
                    byte_mask_lane1_n, byte_mask_lane0_n};
        if (narrow_mode) begin
            lane_en = lane_en & `LANE_EN_NARROW;
        end
    end

    // a beat with every lane masked is aborted and its data dropped
    assign beat_push = (wr_beat0 | wr_beat1) & (lane_en != `LANE_EN_NONE);

    // ------------------------------------------------------------
    // write buffer and array update
    // ------------------------------------------------------------
    wire                    buf_valid;
    wire                    buf_ready;
    wire [`WBUF_W-1:0]      buf_word;
    wire [`ADDR_W-1:0]      buf_addr;
    wire [`DATA_W-1:0]      buf_data;
    wire [`LANES-1:0]       buf_lanes;
    integer                 l;

    burst2_fifo #(
        .WIDTH (`WBUF_W),
        .DEPTH (`WBUF_DEPTH),
        .PTR_W (`WBUF_PTR_W)
    ) u_write_buffer (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (beat_push),
        .in_ready  (fifo_in_ready),
        .in_data   ({beat_addr, dq_in, lane_en}),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_word)
    );

    // a beat that meets a full buffer is lost; this warns the controller
    assign write_buffer_ready = fifo_in_ready;

    // the array port is shared: buffered writes wait while a read is in flight
    // reads never wait for the buffer, so read latency stays fixed
    assign buf_ready = ~read_busy;
    assign buf_addr  = buf_word[`WBUF_W-1:`WBUF_W-`ADDR_W];
    assign buf_data  = buf_word[`DATA_W+`LANES-1:`LANES];
    assign buf_lanes = buf_word[`LANES-1:0];

    always @(posedge clock) begin
        if (buf_valid & buf_ready) begin
            for (l = 0; l < `LANES; l = l + 1) begin
                if (buf_lanes[l]) begin
                    mem_r[buf_addr][l*`LANE_W +: `LANE_W]
                        <= buf_data[l*`LANE_W +: `LANE_W];
                end
            end
        end
    end

endmodule // burst2_cio_sram_port

/* tb/burst2_port_properties.sv */
// port checker for the burst-of-two sram port
`timescale 1ns/10ps
`include "burst2_consts.vh"
module burst2_port_checker (
    // clock and reset
    input wire               clock,
    input wire               rst,
    // command and bus
    input wire               load_strobe_n,
    input wire               rw_select,
    input wire               k_rise,
    input wire [`DATA_W-1:0] dq_oe
);
    wire rd_cmd = k_rise && !load_strobe_n && rw_select;
    wire wr_cmd = k_rise && !load_strobe_n && !rw_select;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    read_latency_a: assert property (rd_cmd |-> ##4 (&dq_oe) ##1 (&dq_oe))
        else $error("read burst not driven in its two cycles");
    oe_cause_a: assert property ($rose(dq_oe[0]) |-> $past(rd_cmd, 4))
        else $error("data pins driven without a read");
    idle_release_a: assert property (rd_cmd ##2 !rd_cmd |-> ##4 (dq_oe == 36'h0))
        else $error("data pins not released after burst");
    write_no_drive_a: assert property (wr_cmd |-> ##4 !dq_oe[0] ##1 !dq_oe[0])
        else $error("write command made pins drive");
    oe_uniform_a: assert property ((dq_oe == 36'h0) || (&dq_oe))
        else $error("output enables disagree");
    k_phase_a: assert property (!k_rise |=> k_rise)
        else $error("k phase did not alternate");
    burst_len_a: assert property ($rose(dq_oe[0]) |=> dq_oe[0])
        else $error("read burst shorter than two words");
endmodule // burst2_port_checker

bind burst2_cio_sram_port burst2_port_checker u_chk (.clock(clock), .rst(rst),
    .load_strobe_n(load_strobe_n), .rw_select(rw_select), .k_rise(k_rise), .dq_oe(dq_oe));

/* tb/burst2_ctrl_model.sv */
// controller side of the common data bus
`timescale 1ns/10ps
`include "burst2_consts.vh"
module burst2_ctrl_model (
    // clock
    input  wire               clock,
    // bench drive request
    input  wire               drive_en,
    input  wire [`DATA_W-1:0] drive_data,
    // device side
    input  wire [`DATA_W-1:0] dq_out,
    input  wire [`DATA_W-1:0] dq_oe,
    output wire [`DATA_W-1:0] dq_in
);
    reg [`DATA_W-1:0] last_r = 36'h0;
    // released bus toggles every cycle so stale data never passes
    assign dq_in = dq_oe[0] ? dq_out : (drive_en ? drive_data : ~last_r);
    always @(posedge clock) begin
        last_r <= dq_in;
    end
endmodule // burst2_ctrl_model

/* tb/burst2_cio_sram_port_tb.sv */
// self-checking bench for the burst-of-two sram port
`timescale 1ns/10ps
`include "burst2_consts.vh"
module burst2_cio_sram_port_tb;
    reg                clock, rst, load_strobe_n, rw_select, narrow_mode, drive_en;
    reg  [3:0]         address, mask_n;
    reg  [35:0]        drive_data;
    reg  [35:0]        mem_ref [0:15];
    reg  [15:0]        seed;
    wire [35:0]        dq_in, dq_out, dq_oe;
    wire               k_rise, write_buffer_ready;
    integer            n_errors, cmp_count, i;

    burst2_cio_sram_port u_dut (.clock(clock), .rst(rst), .load_strobe_n(load_strobe_n),
        .rw_select(rw_select), .address(address), .narrow_mode(narrow_mode),
        .byte_mask_lane0_n(mask_n[0]), .byte_mask_lane1_n(mask_n[1]),
        .byte_mask_lane2_n(mask_n[2]), .byte_mask_lane3_n(mask_n[3]), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .k_rise(k_rise), .write_buffer_ready(write_buffer_ready));
    burst2_ctrl_model u_ctrl (.clock(clock), .drive_en(drive_en), .drive_data(drive_data),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));

    function [15:0] lfsr_next(input [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [35:0] rword(input [15:0] s);
        rword = {s[3:0], s, ~s};
    endfunction
    function [35:0] merge(input [35:0] old, input [35:0] d, input [3:0] m, input nar);
        integer l;
        begin
            merge = old;
            for (l = 0; l < 4; l = l + 1) begin
                if (!m[l] && !(nar && l > 1)) merge[9*l +: 9] = d[9*l +: 9];
            end
        end
    endfunction

    task check(input [8*8-1:0] what, input [35:0] exp, input [35:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // read at j=0, write command at j=2, write beats at j=8 and j=9
    task burst(input do_rd, input do_wr, input [3:0] ard, input [3:0] awr,
               input [35:0] d0, input [35:0] d1, input [3:0] m0, input [3:0] m1);
        integer j;
        begin
            while (k_rise !== 1'b1) @(negedge clock);
            for (j = 0; j < 20; j = j + 1) begin
                load_strobe_n = (j == 0) ? !do_rd : ((j == 2) ? !do_wr : 1'b1);
                drive_en = do_wr && (j == 8 || j == 9);
                if (j == 0) begin
                    rw_select = 1'b1;
                    address = ard;
                end
                if (j == 2) begin
                    rw_select = 1'b0;
                    address = awr;
                end
                if (j >= 3 && j <= 6)
                    check("oe", (do_rd && j > 3 && j < 6) ? ~36'h0 : 36'h0, dq_oe);
                if (do_rd && j == 4) check("word0", mem_ref[ard], dq_out);
                if (do_rd && j == 5) check("word1", mem_ref[ard ^ 4'h1], dq_out);
                if (do_wr && j == 8) check("wbr", 36'h1, {35'h0, write_buffer_ready});
                if (do_wr && (j == 8 || j == 9)) begin
                    drive_data = (j == 8) ? d0 : d1;
                    mask_n = (j == 8) ? m0 : m1;
                    mem_ref[awr ^ (j - 8)] = merge(mem_ref[awr ^ (j - 8)], drive_data,
                                                   mask_n, narrow_mode);
                end
                @(negedge clock);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #50000;
        n_errors = n_errors + 1;
        tally_and_finish;
    end
    initial begin
        {rst, load_strobe_n, rw_select, narrow_mode, drive_en} = 5'h1c;
        {address, mask_n, drive_data} = {4'h0, 4'hf, 36'h0};
        {n_errors, cmp_count, seed} = {32'h0, 32'h0, 16'h652c};
        repeat (16) @(negedge clock);
        rst = 1'b0;
        for (i = 0; i < 16; i = i + 2) begin
            seed = lfsr_next(seed);
            burst(1'b0, 1'b1, 4'h0, i[3:0], rword(seed), rword(~seed), 4'h0, 4'h0);
        end
        for (i = 0; i < 40; i = i + 1) begin
            seed = lfsr_next(seed);
            narrow_mode = (i == 1) ? 1'b1 : seed[0];
            burst(1'b1, 1'b1, seed[15:12], seed[3:0], rword(seed), rword(lfsr_next(seed)),
                  (i < 2) ? {4{i == 0}} : seed[7:4], (i < 2) ? {4{i == 0}} : seed[11:8]);
        end
        for (i = 0; i < 16; i = i + 2) burst(1'b1, 1'b0, i[3:0], 4'h0, 36'h0, 36'h0, 4'hf, 4'hf);
        tally_and_finish;
    end
endmodule // burst2_cio_sram_port_tb
